// file: verilog/adc_config_and_pin_control.sv
`timescale 1ns/100ps

module adc_config_and_pin_control #(
  parameter int CHANNELS = conv_cfg_pkg::CHANNELS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [conv_cfg_pkg::ADDR_W-1:0] regAddr,
  input wire logic [conv_cfg_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [conv_cfg_pkg::DATA_W-1:0] regRdata,
  input wire logic alternate_clock,
  input wire logic converter_async_clock,
  output logic conversion_clock,
  output logic conversionTick,
  output logic lowPowerSelect,
  output logic longSampleSelect,
  output logic tenBitMode,
  output logic modeReserved,
  output logic resultInvalidate,
  input wire logic [CHANNELS-1:0] portOut,
  input wire logic [CHANNELS-1:0] portOe,
  input wire logic [CHANNELS-1:0] portPullup,
  output logic [CHANNELS-1:0] portIn,
  input wire logic [CHANNELS-1:0] padIn,
  output logic [CHANNELS-1:0] padOut,
  output logic [CHANNELS-1:0] padOe,
  output logic [CHANNELS-1:0] padPullupEn,
  output logic [CHANNELS-1:0] analogPinSelect
);

  // =====================================================================
  // Register file
  // =====================================================================
  logic [conv_cfg_pkg::DATA_W-1:0] config_q, config_d;
  logic [conv_cfg_pkg::DATA_W-1:0] pinLow_q, pinLow_d;
  logic [conv_cfg_pkg::DATA_W-1:0] pinMid_q, pinMid_d;
  logic [conv_cfg_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic invalidate_q, invalidate_d;
  logic [1:0] newMode;

  // Read data is zero outside its answer cycle, so a stale value never sits on the bus
  always_comb begin
    config_d = config_q;
    pinLow_d = pinLow_q;
    pinMid_d = pinMid_q;
    rdata_d = '0;
    invalidate_d = 1'b0;
    newMode = regWdata[conv_cfg_pkg::MODE_MSB:conv_cfg_pkg::MODE_LSB];
    if (regWrite) begin
      unique case (regAddr)
        conv_cfg_pkg::CONFIG_OFFSET: begin
          config_d = regWdata;
          // Only a change of the mode code discards results, even between codes with the same resolution; rewriting the same mode keeps them
          if (newMode != config_q[conv_cfg_pkg::MODE_MSB:conv_cfg_pkg::MODE_LSB]) begin
            invalidate_d = 1'b1;
          end
        end
        conv_cfg_pkg::PIN_LOW_OFFSET: begin
          pinLow_d = regWdata;
        end
        conv_cfg_pkg::PIN_MID_OFFSET: begin
          pinMid_d = regWdata;
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        conv_cfg_pkg::CONFIG_OFFSET: begin
          rdata_d = config_q;
        end
        conv_cfg_pkg::PIN_LOW_OFFSET: begin
          rdata_d = pinLow_q;
        end
        conv_cfg_pkg::PIN_MID_OFFSET: begin
          rdata_d = pinMid_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      config_q <= conv_cfg_pkg::CONFIG_RESET;
      pinLow_q <= conv_cfg_pkg::PIN_RESET;
      pinMid_q <= conv_cfg_pkg::PIN_RESET;
      rdata_q <= '0;
      invalidate_q <= 1'b0;
    end else begin
      config_q <= config_d;
      pinLow_q <= pinLow_d;
      pinMid_q <= pinMid_d;
      rdata_q <= rdata_d;
      invalidate_q <= invalidate_d;
    end
  end

  assign regRdata = rdata_q;
  assign resultInvalidate = invalidate_q;

  // =====================================================================
  // Decoded configuration
  // =====================================================================
  logic lowPower_q, lowPower_d;
  logic longSample_q, longSample_d;
  logic tenBit_q, tenBit_d;
  logic reserved_q, reserved_d;
  logic [1:0] modeField;

  // Decoded bits trail the register by one cycle so each output has its own flop
  always_comb begin
    modeField = config_q[conv_cfg_pkg::MODE_MSB:conv_cfg_pkg::MODE_LSB];
    lowPower_d = config_q[conv_cfg_pkg::LOW_POWER_BIT];
    longSample_d = config_q[conv_cfg_pkg::LONG_SAMPLE_BIT];
    tenBit_d = (modeField == conv_cfg_pkg::MODE_10BIT);
    // Reserved codes fall back to 8-bit operation and raise a flag
    reserved_d = (modeField != conv_cfg_pkg::MODE_10BIT) && (modeField != conv_cfg_pkg::MODE_8BIT);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lowPower_q <= 1'b0;
      longSample_q <= 1'b0;
      tenBit_q <= 1'b0;
      reserved_q <= 1'b0;
    end else begin
      lowPower_q <= lowPower_d;
      longSample_q <= longSample_d;
      tenBit_q <= tenBit_d;
      reserved_q <= reserved_d;
    end
  end

  assign lowPowerSelect = lowPower_q;
  assign longSampleSelect = longSample_q;
  assign tenBitMode = tenBit_q;
  assign modeReserved = reserved_q;

  // =====================================================================
  // Clock source synchronisers
  // =====================================================================
  // Outside clocks are sampled on core_clk, so they must run below a quarter of it
  logic [conv_cfg_pkg::SYNC_STAGES-1:0] altSync_q, altSync_d;
  logic [conv_cfg_pkg::SYNC_STAGES-1:0] asyncSync_q, asyncSync_d;
  logic altLevel_q, altLevel_d;
  logic asyncLevel_q, asyncLevel_d;
  logic altRise_q, altRise_d;
  logic asyncRise_q, asyncRise_d;
  logic busHalf_q, busHalf_d;

  always_comb begin
    altSync_d = {altSync_q[1:0], alternate_clock};
    asyncSync_d = {asyncSync_q[1:0], converter_async_clock};
    altLevel_d = altLevel_q;
    asyncLevel_d = asyncLevel_q;
    if (altSync_q[1] == altSync_q[2]) begin
      altLevel_d = altSync_q[2];
    end
    if (asyncSync_q[1] == asyncSync_q[2]) begin
      asyncLevel_d = asyncSync_q[2];
    end
    // Filtered levels idle low like the pins, so leaving reset gives no false rising edge
    altRise_d = altLevel_d && !altLevel_q;
    asyncRise_d = asyncLevel_d && !asyncLevel_q;
    // Free-running toggle: one source tick on every second bus clock
    busHalf_d = ~busHalf_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      altSync_q <= '0;
      asyncSync_q <= '0;
      altLevel_q <= 1'b0;
      asyncLevel_q <= 1'b0;
      altRise_q <= 1'b0;
      asyncRise_q <= 1'b0;
      busHalf_q <= 1'b0;
    end else begin
      altSync_q <= altSync_d;
      asyncSync_q <= asyncSync_d;
      altLevel_q <= altLevel_d;
      asyncLevel_q <= asyncLevel_d;
      altRise_q <= altRise_d;
      asyncRise_q <= asyncRise_d;
      busHalf_q <= busHalf_d;
    end
  end

  // =====================================================================
  // Input clock select and divider
  // =====================================================================
  logic srcTick;

  // The bus source is a plain enable and bus/2 a free-running toggle; alternate and async are one-cycle pulses from filtered edges
  always_comb begin
    unique case (config_q[conv_cfg_pkg::CLKSEL_MSB:conv_cfg_pkg::CLKSEL_LSB])
      conv_cfg_pkg::CLKSEL_BUS: begin
        srcTick = 1'b1;
      end
      conv_cfg_pkg::CLKSEL_BUS_HALF: begin
        srcTick = busHalf_q;
      end
      conv_cfg_pkg::CLKSEL_ALT: begin
        srcTick = altRise_q;
      end
      conv_cfg_pkg::CLKSEL_ASYNC: begin
        srcTick = asyncRise_q;
      end
    endcase
  end

  // Counting ticks rather than clocking on the sources keeps every input clock in the core_clk domain
  conv_clock_divider divider (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .srcTick(srcTick),
    .divideSel(config_q[conv_cfg_pkg::DIVIDE_MSB:conv_cfg_pkg::DIVIDE_LSB]),
    .convTick(conversionTick),
    .convClk(conversion_clock)
  );

  // =====================================================================
  // Pin control
  // =====================================================================
  logic [CHANNELS-1:0] pinDisable;
  logic [CHANNELS-1:0] padOut_q, padOut_d;
  logic [CHANNELS-1:0] padOe_q, padOe_d;
  logic [CHANNELS-1:0] pullup_q, pullup_d;
  logic [CHANNELS-1:0] portIn_q, portIn_d;
  logic [CHANNELS-1:0] padLevel_q, padLevel_d;
  // Three-stage pad sampling; a lone sample on the first stage never reaches the port
  logic [CHANNELS-1:0] padS0_q;
  logic [CHANNELS-1:0] padS1_q;
  logic [CHANNELS-1:0] padS2_q;

  // Mid register bits sit above the low register, on channels 8 to 15
  assign pinDisable = {pinMid_q, pinLow_q};

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_pin
      always_comb begin
        padLevel_d[ch] = padLevel_q[ch];
        if (padS1_q[ch] == padS2_q[ch]) begin
          padLevel_d[ch] = padS2_q[ch];
        end
        // A disabled pin has no output drive, no input and no pullup
        padOut_d[ch] = pinDisable[ch] ? 1'b0 : portOut[ch];
        padOe_d[ch] = pinDisable[ch] ? 1'b0 : portOe[ch];
        pullup_d[ch] = pinDisable[ch] ? 1'b0 : portPullup[ch];
        portIn_d[ch] = pinDisable[ch] ? 1'b0 : padLevel_q[ch];
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      padS0_q <= '0;
      padS1_q <= '0;
      padS2_q <= '0;
      padLevel_q <= '0;
      padOut_q <= '0;
      padOe_q <= '0;
      pullup_q <= '0;
      portIn_q <= '0;
    end else begin
      padS0_q <= padIn;
      padS1_q <= padS0_q;
      padS2_q <= padS1_q;
      padLevel_q <= padLevel_d;
      padOut_q <= padOut_d;
      padOe_q <= padOe_d;
      pullup_q <= pullup_d;
      portIn_q <= portIn_d;
    end
  end

  assign padOut = padOut_q;
  assign padOe = padOe_q;
  assign padPullupEn = pullup_q;
  assign portIn = portIn_q;
  assign analogPinSelect = pinDisable;

endmodule : adc_config_and_pin_control

// file: verilog/conv_cfg_pkg.sv
package conv_cfg_pkg;

  // =====================================================================
  // Register port
  // =====================================================================
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] PIN_LOW_OFFSET = 8'h01;
  localparam logic [ADDR_W-1:0] PIN_MID_OFFSET = 8'h02;

  // =====================================================================
  // Configuration fields
  // =====================================================================
  localparam int LOW_POWER_BIT = 7;
  localparam int DIVIDE_MSB = 6;
  localparam int DIVIDE_LSB = 5;
  localparam int LONG_SAMPLE_BIT = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 2;
  localparam int CLKSEL_MSB = 1;
  localparam int CLKSEL_LSB = 0;

  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h2;

  localparam logic [1:0] CLKSEL_BUS = 2'h0;
  localparam logic [1:0] CLKSEL_BUS_HALF = 2'h1;
  localparam logic [1:0] CLKSEL_ALT = 2'h2;
  localparam logic [1:0] CLKSEL_ASYNC = 2'h3;

  // =====================================================================
  // Reset values and sizes
  // =====================================================================
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PIN_RESET = 8'h00;
  localparam int CHANNELS = 16;
  localparam int SYNC_STAGES = 3;
  localparam int DIV_CNT_W = 3;

endpackage : conv_cfg_pkg

// file: verilog/conv_clock_divider.sv
`timescale 1ns/100ps

module conv_clock_divider (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic srcTick,
  input wire logic [1:0] divideSel,
  output logic convTick,
  output logic convClk
);

  // =====================================================================
  // Divide by 1, 2, 4 or 8 source ticks
  // =====================================================================
  logic [conv_cfg_pkg::DIV_CNT_W-1:0] cnt_q, cnt_d;
  logic [conv_cfg_pkg::DIV_CNT_W-1:0] terminal;
  logic tick_q, tick_d;
  logic clk_q, clk_d;

  always_comb begin
    terminal = conv_cfg_pkg::DIV_CNT_W'((4'h1 << divideSel) - 4'h1);
    cnt_d = cnt_q;
    tick_d = 1'b0;
    clk_d = clk_q;
    if (srcTick) begin
      // A smaller ratio written mid-count must not strand the counter above it
      if (cnt_q >= terminal) begin
        cnt_d = '0;
        tick_d = 1'b1;
        clk_d = ~clk_q;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      clk_q <= clk_d;
    end
  end

  assign convTick = tick_q;
  assign convClk = clk_q;

endmodule : conv_clock_divider

// file: tb/conv_cfg_chk.sv
`timescale 1ns/100ps

module conv_cfg_chk #(
  parameter int CHANNELS = 16
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic lowPowerSelect,
  input wire logic longSampleSelect,
  input wire logic tenBitMode,
  input wire logic modeReserved,
  input wire logic resultInvalidate,
  input wire logic [CHANNELS-1:0] portOe,
  input wire logic [CHANNELS-1:0] portIn,
  input wire logic [CHANNELS-1:0] padOut,
  input wire logic [CHANNELS-1:0] padOe,
  input wire logic [CHANNELS-1:0] padPullupEn,
  input wire logic [CHANNELS-1:0] analogPinSelect
);
  // ==========================================================
  // Register and pin relations
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic cfgWr;
  assign cfgWr = regWrite && regAddr == conv_cfg_pkg::CONFIG_OFFSET;

  a_low_power_follow: assert property (cfgWr |-> ##2 lowPowerSelect == $past(regWdata[7], 2))
    else $error("low power select does not follow config write");
  a_long_sample_follow: assert property (cfgWr |-> ##2 longSampleSelect == $past(regWdata[4], 2))
    else $error("long sample select does not follow config write");
  a_mode_decode_ok: assert property (cfgWr |-> ##2 tenBitMode == ($past(regWdata[3:2], 2) == 2'h2)
    && modeReserved == $past(regWdata[2], 2)) else $error("mode decode wrong");
  a_invalidate_cause: assert property (resultInvalidate |-> $past(cfgWr))
    else $error("invalidate without config write");
  a_pin_write_lands: assert property (regWrite && regAddr == conv_cfg_pkg::PIN_LOW_OFFSET
    |=> analogPinSelect[7:0] == $past(regWdata)) else $error("pin low write lost");
  a_pin_readback: assert property (regRead && regAddr == conv_cfg_pkg::PIN_MID_OFFSET
    |=> regRdata == analogPinSelect[15:8]) else $error("pin mid readback wrong");
  a_read_idle_zero: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not zero outside read");
  a_pad_enable_pass: assert property (1'b1 |=> padOe == ($past(portOe) & ~$past(analogPinSelect)))
    else $error("pad enable wrong");
  a_disabled_pin_quiet: assert property (1'b1 |=>
    ((padOut | padPullupEn | portIn) & $past(analogPinSelect)) == '0) else $error("disabled pin active");

  c_invalidate: cover property (resultInvalidate);
  c_ten_bit: cover property (tenBitMode);
  c_pin_read: cover property (regRead && regAddr == conv_cfg_pkg::PIN_MID_OFFSET ##1 regRdata != 8'h00);
endmodule : conv_cfg_chk

bind adc_config_and_pin_control conv_cfg_chk #(.CHANNELS(CHANNELS)) chk_u (.core_clk(core_clk),
  .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .lowPowerSelect(lowPowerSelect), .longSampleSelect(longSampleSelect),
  .tenBitMode(tenBitMode), .modeReserved(modeReserved), .resultInvalidate(resultInvalidate),
  .portOe(portOe), .portIn(portIn), .padOut(padOut), .padOe(padOe), .padPullupEn(padPullupEn),
  .analogPinSelect(analogPinSelect));

// file: tb/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin numErrors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module testbench;
  localparam logic [7:0] CFG = conv_cfg_pkg::CONFIG_OFFSET;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic alternate_clock = 1'b0;
  logic converter_async_clock = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [15:0] portOut = 16'h0000;
  logic [15:0] portOe = 16'h0000;
  logic [15:0] portPullup = 16'h0000;
  logic [15:0] padIn = 16'h0000;
  logic [15:0] portIn, padOut, padOe, padPullupEn, analogPinSelect;
  logic conversion_clock, conversionTick, lowPowerSelect, longSampleSelect, tenBitMode, modeReserved;
  logic resultInvalidate;
  int numErrors = 0;
  int comparisons = 0;

  always #5 core_clk = ~core_clk;
  // Edges never meet core_clk rising edges, so tick gaps come out exact
  always #100 alternate_clock = ~alternate_clock;
  always #80 converter_async_clock = ~converter_async_clock;

  adc_config_and_pin_control dut_u (.core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .alternate_clock(alternate_clock), .converter_async_clock(converter_async_clock),
    .conversion_clock(conversion_clock), .conversionTick(conversionTick), .lowPowerSelect(lowPowerSelect),
    .longSampleSelect(longSampleSelect), .tenBitMode(tenBitMode), .modeReserved(modeReserved),
    .resultInvalidate(resultInvalidate), .portOut(portOut), .portOe(portOe), .portPullup(portPullup),
    .portIn(portIn), .padIn(padIn), .padOut(padOut), .padOe(padOe), .padPullupEn(padPullupEn),
    .analogPinSelect(analogPinSelect));

  // ==========================================================
  // Bus and measurement tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    `CHK("read data", e, regRdata)
  endtask : rd

  // Third gap is taken so the divider has settled after a ratio change
  task automatic tickGap(input int expGap);
    int n;
    logic lvl;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      lvl = conversion_clock;
      do begin
        @(posedge core_clk);
        #1;
        n++;
      end while (conversionTick !== 1'b1 && n < 300);
    end
    `CHK("tick gap", expGap, n)
    `CHK("conversion clock", ~lvl, conversion_clock)
  endtask : tickGap

  // ==========================================================
  // Scenarios
  task automatic testReset;
    rd(CFG, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    tickGap(1);
    $display("reset test done");
  endtask : testReset

  task automatic testConfig;
    logic [1:0] modes[5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h0};
    logic [1:0] prev = 2'h0;
    wr(CFG, 8'h90);
    @(posedge core_clk);
    #1;
    `CHK("low power", 1'b1, lowPowerSelect)
    `CHK("long sample", 1'b1, longSampleSelect)
    rd(CFG, 8'h90);
    wr(CFG, 8'h00);
    @(posedge core_clk);
    #1;
    `CHK("high speed", 1'b0, lowPowerSelect)
    `CHK("short sample", 1'b0, longSampleSelect)
    foreach (modes[i]) begin
      wr(CFG, {4'h0, modes[i], 2'h0});
      `CHK("invalidate", modes[i] != prev, resultInvalidate)
      @(posedge core_clk);
      #1;
      `CHK("ten bit", modes[i] == 2'h2, tenBitMode)
      `CHK("reserved", modes[i][0], modeReserved)
      prev = modes[i];
    end
    $display("config test done");
  endtask : testConfig

  task automatic testDivide;
    for (int d = 0; d < 4; d++) begin
      wr(CFG, {1'b0, d[1:0], 5'h00});
      tickGap(1 << d);
    end
    wr(CFG, 8'h21);
    tickGap(4);
    wr(CFG, 8'h02);
    tickGap(20);
    wr(CFG, 8'h23);
    tickGap(32);
    wr(CFG, 8'h00);
    $display("divide test done");
  endtask : testDivide

  task automatic testPins;
    @(posedge core_clk);
    portOut <= 16'hffff;
    portOe <= 16'hffff;
    portPullup <= 16'hffff;
    padIn <= 16'hffff;
    wr(8'h01, 8'ha5);
    wr(8'h02, 8'h3c);
    `CHK("pin select", 16'h3ca5, analogPinSelect)
    rd(8'h02, 8'h3c);
    rd(8'h01, 8'ha5);
    repeat (8) @(posedge core_clk);
    #1;
    `CHK("pad enable", 16'hc35a, padOe)
    `CHK("pad out", 16'hc35a, padOut)
    `CHK("pullup", 16'hc35a, padPullupEn)
    `CHK("port in", 16'hc35a, portIn)
    wr(8'h01, 8'h00);
    wr(8'h02, 8'h00);
    @(posedge core_clk);
    #1;
    `CHK("pad enable free", 16'hffff, padOe)
    $display("pin test done");
  endtask : testPins

  task automatic testUnmapped;
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00);
    rd(CFG, 8'h00);
    $display("unmapped test done");
  endtask : testUnmapped

  task automatic testDone;
    $display("comparisons %0d mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : testDone

  initial begin
    #100us;
    numErrors++;
    testDone();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    testReset();
    testConfig();
    testDivide();
    testPins();
    testUnmapped();
    testDone();
  end
endmodule : testbench
